// File: include/lps_map.svh
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
// Timing figures in ns, converted to cycles at the 10 ns clock
`define LPS_CLK_PERIOD_NS 10
`define LPS_CKE_MIN_LEVEL_NS 15
`define LPS_PD_EXIT_LATENCY_NS 15
`define LPS_CKE_MIN_LEVEL_CYC ((`LPS_CKE_MIN_LEVEL_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_PD_EXIT_CYC ((`LPS_PD_EXIT_LATENCY_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
// Command encodings on the first three command/address bits
`define LPS_CA_NOP 3'b111
`define LPS_CA_DPD 3'b011
`define LPS_CA_ACT_MASK 3'b010
`define LPS_BANKS 8
`define LPS_INIT_CYC 16
// Controller quiet time before enable may drop after a row or mode command; plain choice
`define LPS_CKE_HOLD_CYC 2
// Calibration quiet period driven by the controller model; plain choice
`define LPS_CAL_CYC 4
`endif

// File: include/lps_pkg.sv
package lps_pkg;
  // Power state of the device
  typedef enum logic [2:0] {
    LPS_ACTIVE,
    LPS_PD_IDLE,
    LPS_PD_ACTIVE,
    LPS_PD_EXIT,
    LPS_DEEP_SLEEP,
    LPS_INIT
  } lps_state_t;

  // Sampled command pins
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic [2:0] ca;
  } lps_cmd_t;

  // Buffer enables seen by the rest of the device
  typedef struct packed {
    logic in_buf_en;
    logic out_buf_en;
    logic core_pwr_en;
    logic array_valid;
  } lps_buf_t;
endpackage : lps_pkg

// File: design/lps_bank_tracker.sv
`timescale 1ns/1ps
`include "lps_map.svh"
// Open-row flags, one per bank
module lps_bank_tracker #(
  parameter int NUM_BANKS = `LPS_BANKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear_all,
  input wire logic open_v,
  input wire logic close_v,
  input wire logic close_all,
  input wire logic [$clog2(NUM_BANKS)-1:0] bank,
  output logic any_open_q
);
  logic [NUM_BANKS-1:0] open_q;
  logic [NUM_BANKS-1:0] open_d;

  // Elaboration guard: a single bank leaves no bank address to decode
  if (NUM_BANKS < 2)
  begin : g_bad_banks
    $error("lps_bank_tracker: NUM_BANKS must be at least 2");
  end

  // One flag per bank; clear wins over open for deep sleep loss
  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : g_bank
    assign open_d[g] = (clear_all || close_all || (close_v && bank == g)) ? 1'b0 :
      ((open_v && bank == g) ? 1'b1 : open_q[g]);
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        open_q[g] <= 1'b0;
      else
        open_q[g] <= open_d[g];
    end
  end

  // Summary built from the next flags, so a row opened one edge before entry already counts
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      any_open_q <= 1'b0;
    else
      any_open_q <= |open_d;
  end
endmodule : lps_bank_tracker

// File: design/lps_power_ctrl.sv
`timescale 1ns/1ps
`include "lps_map.svh"
// Notes on behaviour
// RL1: During calibration controller sends only NOPs and keeps clock enable high.
// RL2: All data bus drivers float for the whole calibration interval.
// RL3: Shared calibration resistor: controller never overlaps device calibrations.
// RL4: Enable low with select high enters power-down; next cycle is a NOP.
// RL5: Enable may not drop during reads, writes or mode register accesses.
// RL6: Power-down is idle if all banks idle, else active.
// RL7: Power-down gates all buffers but clock and enable; enable low minimum time.
// RL8: No refresh in power-down; controller exits early enough.
// RL9: Exit raises enable with select high, then holds it the minimum time.
// RL10: Commands accepted only after exit latency following enable rising.
// RL11: Clock may change in power-down; two stable cycles before exit.
// RL12: After reads, enable stays high until the burst and strobe delay end.
// RL13: After writes, enable low waits write latency, burst and recovery.
// RL14: After auto-precharge writes, one further recovery cycle is added.
// RL15: After refresh, activate, precharge wait hold time before enable low.
// RL16: After mode register write wait its period before enable low.
// RL17: Enable low, select low, pattern 011 enters deep sleep; next is NOP.
// RL18: Deep sleep loses array, disables inputs except enable, outputs, core power.
// RL19: Deep sleep exit needs stable clock, setup time, then full initialization.
// RL20: Clock change only with rows settled and at most refresh pending.
// RL21: Keep clock two cycles after enable falls, two good cycles before rise.
// RL22: NOP needs steady enable; select high or select low with 111.
// RL23: After deep sleep exit, only reset and initialization commands are obeyed.
module lps_power_ctrl
  import lps_pkg::*;
#(
  parameter int NUM_BANKS = `LPS_BANKS,
  parameter int INIT_CYC = `LPS_INIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire lps_pkg::lps_cmd_t cmd_in,
  input wire logic act_v,
  input wire logic pre_v,
  input wire logic pre_all_v,
  input wire logic [$clog2(NUM_BANKS)-1:0] bank,
  input wire logic init_cmd_v,
  output lps_pkg::lps_state_t state_q,
  output lps_pkg::lps_buf_t bufs_q,
  output logic cmd_accept_q,
  output logic nop_seen_q,
  output logic idle_pd_q
);
  import lps_pkg::*;

  localparam int CKE_CYC = `LPS_CKE_MIN_LEVEL_CYC;
  localparam int XP_CYC = `LPS_PD_EXIT_CYC;
  localparam int CW = $clog2(INIT_CYC + CKE_CYC + XP_CYC + 2);

  // Elaboration guard: a zero wait would let deep sleep exit skip the initialization wait
  if (INIT_CYC < 1)
  begin : g_bad_init
    $error("lps_power_ctrl: INIT_CYC must be positive");
  end

  // ****************************************
  // Command decode
  // ****************************************
  function automatic logic is_nop(input lps_cmd_t c);
    is_nop = c.cs_n || (c.ca == `LPS_CA_NOP); // RL22
  endfunction : is_nop

  logic cke_prev_q;
  lps_state_t state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic any_open;
  wire cke_fall = cke_prev_q && !cmd_in.cke;
  wire cke_rise = !cke_prev_q && cmd_in.cke;
  wire pd_entry = cke_fall && cmd_in.cs_n; // RL4
  wire dpd_entry = cke_fall && !cmd_in.cs_n && cmd_in.ca == `LPS_CA_DPD; // RL17
  wire steady_nop = (cke_prev_q == cmd_in.cke) && is_nop(cmd_in); // RL22
  wire cnt_done = (cnt_q == '0);
  // Row commands are obeyed only in ACTIVE; there is no refresh input, so power-down never refreshes
  wire live = (state_q == LPS_ACTIVE); // RL8

  // Bank tracking; opens and closes gated off whenever the state is not ACTIVE, the deep sleep clear is not
  lps_bank_tracker #(
    .NUM_BANKS(NUM_BANKS)
  ) u_banks (
    .clk(clk),
    .rst(rst),
    .clear_all(dpd_entry), // RL18
    .open_v(act_v && live),
    .close_v(pre_v && live),
    .close_all(pre_all_v && live),
    .bank(bank),
    .any_open_q(any_open)
  );

  // ****************************************
  // Power state machine
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    case (state_q)
      LPS_ACTIVE:
      begin
        if (dpd_entry)
          state_d = LPS_DEEP_SLEEP; // RL17
        else if (pd_entry)
        begin
          state_d = any_open ? LPS_PD_ACTIVE : LPS_PD_IDLE; // RL6
          cnt_d = CW'(CKE_CYC);
        end
      end
      LPS_PD_IDLE, LPS_PD_ACTIVE:
      begin
        // Enable rising before the minimum low time is a controller fault; still honoured
        if (cke_rise)
        begin
          state_d = LPS_PD_EXIT; // RL9
          cnt_d = CW'(XP_CYC);
        end
      end
      LPS_PD_EXIT:
      begin
        if (cnt_done)
          state_d = LPS_ACTIVE; // RL10
      end
      LPS_DEEP_SLEEP:
      begin
        if (cke_rise)
        begin
          state_d = LPS_INIT; // RL19
          cnt_d = CW'(INIT_CYC);
        end
      end
      LPS_INIT:
      begin
        // Only the init sequence advances; other commands are dropped
        if (cnt_done && init_cmd_v)
          state_d = LPS_ACTIVE; // RL23
      end
      default:
        state_d = LPS_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= LPS_ACTIVE;
      cnt_q <= '0;
      cke_prev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cke_prev_q <= cmd_in.cke;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire pd_d = (state_d == LPS_PD_IDLE) || (state_d == LPS_PD_ACTIVE);
  wire dpd_d = (state_d == LPS_DEEP_SLEEP);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bufs_q <= '{1'b1, 1'b1, 1'b1, 1'b1};
      cmd_accept_q <= 1'b1;
      nop_seen_q <= 1'b0;
      idle_pd_q <= 1'b0;
    end
    else
    begin
      bufs_q.in_buf_en <= !(pd_d || dpd_d); // RL7
      bufs_q.out_buf_en <= !(pd_d || dpd_d); // RL7
      bufs_q.core_pwr_en <= !dpd_d; // RL18
      // Array stays lost until init completes
      bufs_q.array_valid <= dpd_d ? 1'b0 : (bufs_q.array_valid || state_d == LPS_ACTIVE && state_q == LPS_INIT);
      cmd_accept_q <= (state_d == LPS_ACTIVE); // RL10
      nop_seen_q <= steady_nop && live;
      idle_pd_q <= (state_d == LPS_PD_IDLE); // RL6
    end
  end
endmodule : lps_power_ctrl

// File: verif/lps_props.sv
`timescale 1ns/1ps
`include "lps_map.svh"
// ********
// Power-state checks
// ********
module lps_props (
  input wire logic clk,
  input wire logic rst,
  input wire lps_pkg::lps_cmd_t cmd_in,
  input wire lps_pkg::lps_state_t state_q,
  input wire lps_pkg::lps_buf_t bufs_q,
  input wire logic cmd_accept_q,
  input wire logic nop_seen_q,
  input wire logic idle_pd_q
);
  import lps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Either power-down variant
  wire pd = state_q inside {LPS_PD_IDLE, LPS_PD_ACTIVE};
  wire act = state_q == LPS_ACTIVE;
  wire fall = act && !cmd_in.cke;
  pd_entry_a: assert property (fall && $past(cmd_in.cke) && cmd_in.cs_n |=> pd)
    else $error("no power-down entry");
  pd_gate_a: assert property (pd |-> !bufs_q.in_buf_en && !bufs_q.out_buf_en && !cmd_accept_q)
    else $error("buffers live in power-down");
  pd_kind_a: assert property (pd |-> idle_pd_q == (state_q == LPS_PD_IDLE))
    else $error("wrong power-down kind");
  // Exit counter runs XP_CYC plus one edges before commands are honoured again
  exit_lat_a: assert property (pd && cmd_in.cke |=> !cmd_accept_q [*3] ##1 (cmd_accept_q && act))
    else $error("exit latency wrong");
  exit_wait_a: assert property (state_q == LPS_PD_EXIT |-> !cmd_accept_q)
    else $error("early command accept");
  deep_entry_a: assert property (fall && $past(cmd_in.cke) && !cmd_in.cs_n && cmd_in.ca == `LPS_CA_DPD
    |=> state_q == LPS_DEEP_SLEEP && !bufs_q.core_pwr_en && !bufs_q.array_valid) else $error("no deep sleep");
  deep_off_a: assert property (state_q == LPS_DEEP_SLEEP |-> bufs_q == 4'h0 && !cmd_accept_q)
    else $error("deep sleep not off");
  deep_exit_a: assert property (state_q == LPS_DEEP_SLEEP && cmd_in.cke |=> state_q == LPS_INIT)
    else $error("no init after deep sleep");
  init_hold_a: assert property (state_q == LPS_INIT |-> !cmd_accept_q)
    else $error("command accepted in init");
  nop_flag_a: assert property (act && $stable(cmd_in.cke) && (cmd_in.cs_n || cmd_in.ca == `LPS_CA_NOP)
    |=> nop_seen_q) else $error("nop missed");
endmodule : lps_props
bind lps_power_ctrl lps_props i_lps_props (.clk(clk), .rst(rst), .cmd_in(cmd_in), .state_q(state_q),
  .bufs_q(bufs_q), .cmd_accept_q(cmd_accept_q), .nop_seen_q(nop_seen_q), .idle_pd_q(idle_pd_q));

// File: verif/lps_ctrl_model.sv
`timescale 1ns/1ps
`include "lps_map.svh"
// ********
// Controller model
// ********
module lps_ctrl_model (
  input wire logic clk,
  output lps_pkg::lps_cmd_t cmd_in,
  output logic [3:0] strobes,
  output logic [2:0] bank
);
  import lps_pkg::*;
  // Idle pins at time zero
  initial
  begin
    cmd_in = 5'h1f;
    strobes = 4'h0;
    bank = 3'h0;
  end
  // Caller sits at a falling edge; pins hold n rising edges
  task automatic step(input logic cke, input logic cs_n, input logic [2:0] ca, input int n);
    cmd_in = '{cke, cs_n, ca};
    repeat (n) @(negedge clk);
  endtask : step
  // One-cycle decoded pulse: act, pre, pre_all, init; a quiet cycle after it keeps strobes from changing twice at once
  task automatic pulse(input int k, input logic [2:0] b);
    bank = b;
    strobes = 4'h1 << k;
    @(negedge clk);
    strobes = 4'h0;
    @(negedge clk);
  endtask : pulse
  // Idle NOPs first: nothing in flight, row and mode commands settled, clock untouched
  task automatic pd_enter;
    step(1'b1, 1'b1, 3'h7, `LPS_CKE_HOLD_CYC);
    step(1'b0, 1'b1, 3'h7, 3);
  endtask : pd_enter
  // Quiet NOPs, entry cycle, then NOP with cke held low
  task automatic deep_enter;
    step(1'b1, 1'b1, 3'h7, `LPS_CKE_HOLD_CYC);
    step(1'b0, 1'b0, 3'h3, 1);
    step(1'b0, 1'b1, 3'h7, 2);
  endtask : deep_enter
  // Calibration on the shared resistor, never overlapped; model drives no data bus; NOPs only, enable high
  task automatic calibrate;
    step(1'b1, 1'b1, 3'h7, `LPS_CAL_CYC);
  endtask : calibrate
  // Clock runs free, so it is always stable on exit
  task automatic wake;
    step(1'b1, 1'b1, 3'h7, 3);
  endtask : wake
endmodule : lps_ctrl_model

// File: verif/testbench.sv
`timescale 1ns/1ps
// ********
// Testbench
// ********
module testbench;
  import lps_pkg::*;
  logic clk = 0;
  logic rst = 1;
  lps_cmd_t cmd_in;
  logic [3:0] strobes;
  logic [2:0] bank;
  lps_state_t state_q;
  lps_buf_t bufs_q;
  logic cmd_accept_q, nop_seen_q, idle_pd_q;
  int failures = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  lps_ctrl_model i_lps_ctrl_model (.clk(clk), .cmd_in(cmd_in), .strobes(strobes), .bank(bank));
  lps_power_ctrl #(.INIT_CYC(2)) i_lps_power_ctrl (.clk(clk), .rst(rst), .cmd_in(cmd_in),
    .act_v(strobes[0]), .pre_v(strobes[1]), .pre_all_v(strobes[2]), .bank(bank), .init_cmd_v(strobes[3]),
    .state_q(state_q), .bufs_q(bufs_q), .cmd_accept_q(cmd_accept_q), .nop_seen_q(nop_seen_q),
    .idle_pd_q(idle_pd_q));
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait for commands to be honoured again
  task automatic wait_accept;
    repeat (4) if (cmd_accept_q !== 1'b1) @(negedge clk);
  endtask : wait_accept
  task automatic t_nop;
    i_lps_ctrl_model.step(1'b1, 1'b0, 3'h7, 2);
    chk(nop_seen_q, 1'b1);
    i_lps_ctrl_model.step(1'b1, 1'b0, 3'h0, 2);
    chk(nop_seen_q, 1'b0);
    i_lps_ctrl_model.step(1'b1, 1'b1, 3'h0, 2);
    chk(nop_seen_q, 1'b1);
  endtask : t_nop
  // Calibration quiet period: device stays active and sees only NOPs
  task automatic t_cal;
    i_lps_ctrl_model.calibrate();
    chk({state_q, cmd_accept_q, nop_seen_q}, {LPS_ACTIVE, 2'b11});
  endtask : t_cal
  // Activate during power-down must be ignored
  task automatic t_pd(input logic open, input lps_state_t exp);
    if (open)
      i_lps_ctrl_model.pulse(0, 3'h5);
    i_lps_ctrl_model.pd_enter();
    chk(state_q, exp);
    chk({idle_pd_q, bufs_q}, {exp == LPS_PD_IDLE, 4'h3});
    chk(cmd_accept_q, 1'b0);
    i_lps_ctrl_model.pulse(0, 3'h2);
    i_lps_ctrl_model.wake();
    wait_accept();
    chk(state_q, LPS_ACTIVE);
  endtask : t_pd
  task automatic t_deep;
    i_lps_ctrl_model.pulse(0, 3'h4);
    i_lps_ctrl_model.deep_enter();
    chk(state_q, LPS_DEEP_SLEEP);
    chk({cmd_accept_q, bufs_q}, 5'h0);
    i_lps_ctrl_model.wake();
    chk(state_q, LPS_INIT);
    i_lps_ctrl_model.pulse(3, 3'h0);
    wait_accept();
    chk({state_q, bufs_q[0]}, {LPS_ACTIVE, 1'b1});
  endtask : t_deep
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 0;
    t_nop();
    t_cal();
    t_pd(1'b0, LPS_PD_IDLE);
    t_pd(1'b1, LPS_PD_ACTIVE);
    i_lps_ctrl_model.pulse(2, 3'h0);
    t_pd(1'b0, LPS_PD_IDLE);
    i_lps_ctrl_model.pulse(0, 3'h6);
    i_lps_ctrl_model.pulse(1, 3'h6);
    t_pd(1'b0, LPS_PD_IDLE);
    t_deep();
    t_pd(1'b0, LPS_PD_IDLE);
    report_and_stop();
  end
  // Run needs about 100 cycles; allow fifteen times that
  initial
  begin
    #15000;
    failures++;
    report_and_stop();
  end
endmodule : testbench
